// ---- rtl/sarrop_pkg.sv ----
// Constants and types shared by the result-output port.
// Contract
// [R1] Keep N-1 result readable 12 us minimum
// [R2] Host avoids parallel reads after 12 us
// [R3] New result valid within 20 us
// [R4] Data valid 20 ns before busy rises
// [R5] Busy rises after output registers updated
// [R6] Parallel bus drives when selected, serial too
// [R7] Serial data output always driven
// [R8] Chain input cascades only with host clock
// [R9] Clock-source low: device makes shift clock
// [R10] Select and convert low start conversion
// [R11] Internal mode: 16 bits N-1 MSB first
// [R12] Internal bit stable over both edges
// [R13] After 16 pulses clock low, chain level
// [R14] First pulse 1.4 us, period 1.1 us
// [R15] Host clock shifts only when read-selected
// [R16] Host clock treated as asynchronous
// [R17] Host clock at most 10 MHz, 20-70%
// [R18] Host period 100 ns, low 40, high 50
// [R19] Result N readable after or during next
// [R20] Load point between 12 us and busy
// [R21] Host keeps read or clock low then
// [R22] MSB first falling, LSB 16th falling; code shifts on host rising edges instead
// [R23] Chain bits follow from 17th falling edge; code passes them from the 17th rising edge
// [R24] Chain bits pass until next reload
// [R25] Host should not clock during conversion
// [R26] Convert commands ignored while busy low
// [R27] Parallel bus high impedance otherwise
// [R28] Half-word select picks upper or lower byte
// [R29] Format pin high straight binary, low 2s comp
// [R30] Host edges via synchronised edge detector
package sarrop_pkg;
  // Clock and timing
  localparam int CLK_NS = 20;
  localparam int CONV_NS = 18000;
  localparam int LOAD_NS = 17000;
  localparam int INT_START_NS = 1400;
  localparam int INT_PER_NS = 1100;
  localparam logic [9:0] CONV_CYC = 10'(CONV_NS / CLK_NS);
  localparam logic [9:0] LOAD_CYC = 10'(LOAD_NS / CLK_NS);
  localparam logic [9:0] INT_START_CYC = 10'(INT_START_NS / CLK_NS);
  localparam logic [9:0] INT_PER_CYC = 10'(INT_PER_NS / CLK_NS);
  localparam logic [9:0] INT_HI_BEG = 10'(INT_PER_NS / CLK_NS / 4);
  localparam logic [9:0] INT_HI_END = 10'(3 * INT_PER_NS / CLK_NS / 4);
  localparam logic [4:0] NUM_BITS = 5'h10;
  // Register map, byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_RESULT = 12'h008;
  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_TX_BIT = 1;
  localparam int ST_EXT_BIT = 2;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // Internal-clock transmitter states
  typedef enum logic [1:0] {
    SARROP_TX_IDLE = 2'b00,
    SARROP_TX_WAIT = 2'b01,
    SARROP_TX_SEND = 2'b10
  } sarrop_tx_t;
endpackage

// ---- rtl/sarrop_top.sv ----
// Result-output port: conversion timing, parallel and serial readout.
`timescale 1ns/1ps
module sarrop_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic dev_sel_n_in,
  input wire logic read_conv_in,
  input wire logic half_sel_in,
  input wire logic clk_src_ext_in,
  input wire logic output_code_format_in,
  input wire logic chain_in,
  input wire logic serial_shift_clock_in,
  input wire logic [15:0] sar_code_in,
  output logic serial_shift_clock_out,
  output logic serial_shift_clock_oe_n_out,
  output logic serial_result_out,
  output logic [7:0] parallel_result_bus_out,
  output logic parallel_result_bus_oe_n_out,
  output logic busy_n_out,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);

  // Package constants, declared ahead of every use below
  localparam logic [15:0] RESULT_RST_L = sarrop_pkg::RESULT_RST;
  localparam logic [9:0] CONV_CYC = sarrop_pkg::CONV_CYC;
  localparam logic [9:0] LOAD_CYC = sarrop_pkg::LOAD_CYC;
  localparam logic [9:0] INT_START_CYC = sarrop_pkg::INT_START_CYC;
  localparam logic [9:0] INT_PER_CYC = sarrop_pkg::INT_PER_CYC;
  localparam logic [9:0] INT_HI_BEG = sarrop_pkg::INT_HI_BEG;
  localparam logic [9:0] INT_HI_END = sarrop_pkg::INT_HI_END;
  localparam logic [4:0] NUM_BITS = sarrop_pkg::NUM_BITS;

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [6:0] pin_raw;
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;
  logic sclk_prev_r;
  logic cs_n;
  logic rd_sel;
  logic half_sel;
  logic ext_mode;
  logic fmt_sb;
  logic chain_bit;
  logic sclk_s;

  assign pin_raw = {serial_shift_clock_in, chain_in,
                    output_code_format_in, clk_src_ext_in,
                    half_sel_in, read_conv_in, dev_sel_n_in};

  // Two flops on every pin; only the second stage is read
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pin_s1_r <= 7'h01;
      pin_s2_r <= 7'h01;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign cs_n = pin_s2_r[0];
  assign rd_sel = pin_s2_r[1];
  assign half_sel = pin_s2_r[2];
  assign ext_mode = pin_s2_r[3];
  assign fmt_sb = pin_s2_r[4];
  assign chain_bit = pin_s2_r[5];
  assign sclk_s = pin_s2_r[6];

  // Host clock edge detector on the synchronised copy
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      sclk_prev_r <= 1'b0;
    else
      sclk_prev_r <= sclk_s; // see [R16] see [R30]
  end

  logic sclk_rise;
  logic read_en;
  assign sclk_rise = sclk_s & ~sclk_prev_r;
  assign read_en = ~cs_n & rd_sel;

  ////////////////////////////////////////////////////////////////////
  // Convert command and conversion timer
  logic cmd_lvl;
  logic cmd_prev_r;
  logic soft_start_r;
  logic start_req;
  logic conv_start;
  logic converting_r;
  logic [9:0] conv_cnt_r;
  logic load_pt;
  logic conv_end;

  assign cmd_lvl = ~cs_n & ~rd_sel;
  assign start_req = (cmd_lvl & ~cmd_prev_r) | soft_start_r; // see [R10]
  // A command while busy is dropped, not queued
  assign conv_start = start_req & ~converting_r; // see [R26]
  assign load_pt = converting_r & (conv_cnt_r == LOAD_CYC - 10'h001);
  assign conv_end = converting_r & (conv_cnt_r == CONV_CYC - 10'h001);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cmd_prev_r <= 1'b0;
    else
      cmd_prev_r <= cmd_lvl;
  end

  // Counts from the start; load lands 50 cycles (1 us) ahead of busy
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      converting_r <= 1'b0;
      conv_cnt_r <= 10'h000;
    end
    else if (conv_start)
    begin
      converting_r <= 1'b1;
      conv_cnt_r <= 10'h000;
    end
    else if (conv_end)
    begin
      converting_r <= 1'b0; // see [R3]
      conv_cnt_r <= 10'h000;
    end
    else if (converting_r)
      conv_cnt_r <= conv_cnt_r + 10'h001;
  end

  // Busy follows the counter; rises 50 cycles after the load
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      busy_n_out <= 1'b1;
    else if (conv_start)
      busy_n_out <= 1'b0;
    else if (conv_end)
      busy_n_out <= 1'b1; // see [R4] see [R5]
  end

  ////////////////////////////////////////////////////////////////////
  // Output register
  logic [15:0] result_r;
  logic [15:0] code_fmt;

  // Core gives straight binary; flip the MSB for two's complement
  assign code_fmt = fmt_sb ? sar_code_in :
                    {~sar_code_in[15], sar_code_in[14:0]}; // see [R29]

  // N-1 stays until the load point late in conversion N
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      result_r <= RESULT_RST_L;
    else if (load_pt)
      result_r <= code_fmt; // see [R1] see [R20]
  end

  ////////////////////////////////////////////////////////////////////
  // Parallel bus
  // Driven whenever selected for read, in either serial mode
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      parallel_result_bus_oe_n_out <= 1'b1;
      parallel_result_bus_out <= 8'h00;
    end
    else
    begin
      parallel_result_bus_oe_n_out <= ~read_en; // see [R6] see [R27]
      parallel_result_bus_out <= half_sel ? result_r[7:0] :
                                 result_r[15:8]; // see [R28]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Host-clocked shift register
  logic [15:0] ext_sh_r;
  logic ext_serial_result_out_r;

  // Reload at the load point overrides a shift; chain bits
  // keep flowing until then
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ext_sh_r <= RESULT_RST_L;
      ext_serial_result_out_r <= 1'b0;
    end
    else if (load_pt)
      ext_sh_r <= code_fmt; // see [R19] see [R24]
    else if (ext_mode & read_en & sclk_rise) // see [R15]
    begin
      ext_serial_result_out_r <= ext_sh_r[15]; // see [R22]
      ext_sh_r <= {ext_sh_r[14:0], chain_bit}; // see [R8] see [R23]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Internal-clock transmitter
  sarrop_pkg::sarrop_tx_t tx_state_r;
  logic [9:0] tx_cnt_r;
  logic [4:0] tx_bit_r;
  logic [15:0] tx_sh_r;
  logic tx_chain_r;
  logic int_serial_result_out_r;
  logic int_clk_r;
  logic per_end;

  assign per_end = (tx_cnt_r == INT_PER_CYC - 10'h001);

  // Restarted by each internal-mode conversion start; copies N-1 first so the
  // load point cannot disturb a word in flight
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      tx_state_r <= sarrop_pkg::SARROP_TX_IDLE;
      tx_cnt_r <= 10'h000;
      tx_bit_r <= 5'h00;
      tx_sh_r <= RESULT_RST_L;
      tx_chain_r <= 1'b0;
    end
    else if (conv_start & ~ext_mode) // see [R9]
    begin
      tx_state_r <= sarrop_pkg::SARROP_TX_WAIT;
      tx_cnt_r <= 10'h000;
      tx_bit_r <= 5'h00;
      tx_sh_r <= result_r; // see [R11]
      tx_chain_r <= chain_bit; // see [R13]
    end
    else
    begin
      case (tx_state_r)
        sarrop_pkg::SARROP_TX_WAIT:
        begin
          if (tx_cnt_r == INT_START_CYC - 10'h002)
          begin
            tx_state_r <= sarrop_pkg::SARROP_TX_SEND; // see [R14]
            tx_cnt_r <= 10'h000;
          end
          else
            tx_cnt_r <= tx_cnt_r + 10'h001;
        end
        sarrop_pkg::SARROP_TX_SEND:
        begin
          if (per_end)
          begin
            tx_cnt_r <= 10'h000;
            tx_bit_r <= tx_bit_r + 5'h01;
            tx_sh_r <= {tx_sh_r[14:0], 1'b0};
            if (tx_bit_r == NUM_BITS - 5'h01)
              tx_state_r <= sarrop_pkg::SARROP_TX_IDLE;
          end
          else
            tx_cnt_r <= tx_cnt_r + 10'h001;
        end
        default:
          tx_cnt_r <= 10'h000;
      endcase
    end
  end

  // Bit changes with clock low; high sits mid-period
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      int_clk_r <= 1'b0;
      int_serial_result_out_r <= 1'b0;
    end
    else if (tx_state_r == sarrop_pkg::SARROP_TX_SEND)
    begin
      int_clk_r <= (tx_cnt_r >= INT_HI_BEG) &
                   (tx_cnt_r < INT_HI_END); // see [R12]
      int_serial_result_out_r <= tx_sh_r[15];
    end
    else
    begin
      int_clk_r <= 1'b0; // see [R13]
      int_serial_result_out_r <= tx_chain_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial pins
  // Data pin always driven; clock pin driven only in internal mode
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      serial_result_out <= 1'b0;
      serial_shift_clock_out <= 1'b0;
      serial_shift_clock_oe_n_out <= 1'b1;
    end
    else
    begin
      serial_result_out <= ext_mode ? ext_serial_result_out_r :
                           int_serial_result_out_r; // see [R7]
      serial_shift_clock_out <= int_clk_r;
      serial_shift_clock_oe_n_out <= ext_mode; // see [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave
  logic setup_ph;
  logic wr_acc;
  logic hit_ctrl;
  logic hit_status;
  logic hit_result;
  logic [31:0] rd_word;

  assign setup_ph = psel_in & ~penable_in;
  assign wr_acc = psel_in & penable_in & pready_out & pwrite_in;

  // Address decode
  always_comb
  begin
    hit_ctrl = 1'b0;
    hit_status = 1'b0;
    hit_result = 1'b0;
    rd_word = sarrop_pkg::RESET_WORD;
    if (paddr_in == sarrop_pkg::ADDR_CTRL)
      hit_ctrl = 1'b1;
    else if (paddr_in == sarrop_pkg::ADDR_STATUS)
    begin
      hit_status = 1'b1;
      rd_word[sarrop_pkg::ST_BUSY_BIT] = converting_r;
      rd_word[sarrop_pkg::ST_TX_BIT] =
        (tx_state_r != sarrop_pkg::SARROP_TX_IDLE);
      rd_word[sarrop_pkg::ST_EXT_BIT] = ext_mode;
    end
    else if (paddr_in == sarrop_pkg::ADDR_RESULT)
    begin
      hit_result = 1'b1;
      rd_word[15:0] = result_r;
    end
  end

  // Zero-wait: answer in the first access cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= sarrop_pkg::RESET_WORD;
    end
    else
    begin
      pready_out <= setup_ph;
      pslverr_out <= setup_ph & ~(hit_ctrl | hit_status | hit_result);
      prdata_out <= (setup_ph & ~pwrite_in) ? rd_word :
                    sarrop_pkg::RESET_WORD;
    end
  end

  // Start bit is a one-shot; reads of control return zero
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      soft_start_r <= 1'b0;
    else
      soft_start_r <= wr_acc & hit_ctrl &
                      pwdata_in[sarrop_pkg::CTRL_START_BIT];
  end

endmodule // sarrop_top

// ---- bench/sarrop_assertions.sv ----
// Port timing checker for the result-output port.
`timescale 1ns/1ps
module sarrop_assertions (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic dev_sel_n_in,
  input wire logic read_conv_in,
  input wire logic clk_src_ext_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic serial_shift_clock_out,
  input wire logic serial_shift_clock_oe_n_out,
  input wire logic serial_result_out,
  input wire logic parallel_result_bus_oe_n_out,
  input wire logic busy_n_out,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out
);
  logic [9:0] low_r;
  logic [4:0] rise_r;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////
  // Busy-low length; cleared while busy is high
  always_ff @(posedge clk_in)
  begin
    if (rst_in || busy_n_out)
      low_r <= 10'h000;
    else
      low_r <= low_r + 10'h001;
  end
  // Pulses since start; tx outlives busy, so clear on the start only
  always_ff @(posedge clk_in)
  begin
    if (rst_in || $fell(busy_n_out))
      rise_r <= 5'h00;
    else if ($rose(serial_shift_clock_out))
      rise_r <= rise_r + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pin steps, held past the two-stage synchroniser
  sequence rd_sel;
    !dev_sel_n_in && read_conv_in;
  endsequence
  sequence pin_conv;
    busy_n_out && !dev_sel_n_in && read_conv_in
      ##1 (!dev_sel_n_in && !read_conv_in) [*5];
  endsequence
  sequence apb_setup;
    psel_in && !penable_in;
  endsequence
  bus_on_a: assert property (rd_sel [*4]
    |-> !parallel_result_bus_oe_n_out)
    else $error("Bus idle while selected");
  bus_off_a: assert property ((dev_sel_n_in || !read_conv_in) [*4]
    |-> parallel_result_bus_oe_n_out)
    else $error("Bus driven while not selected");
  busy_len_a: assert property ($rose(busy_n_out)
    |-> low_r == 10'h384)
    else $error("Busy low time wrong");
  conv_go_a: assert property (pin_conv |-> !busy_n_out)
    else $error("Pin convert not taken");
  clk_int_a: assert property (!clk_src_ext_in [*4]
    |-> !serial_shift_clock_oe_n_out)
    else $error("Shift clock not driven");
  clk_ext_a: assert property (clk_src_ext_in [*4]
    |-> serial_shift_clock_oe_n_out)
    else $error("Shift clock driven in host mode");
  first_clk_a: assert property ($fell(busy_n_out)
    && !clk_src_ext_in |-> ##[75:90] $rose(serial_shift_clock_out))
    else $error("First pulse late");
  period_a: assert property ($rose(serial_shift_clock_out)
    && rise_r < 5'h0F |-> ##55 $rose(serial_shift_clock_out))
    else $error("Pulse period wrong");
  count_a: assert property ($rose(serial_shift_clock_out)
    |-> rise_r < 5'h10)
    else $error("More than sixteen pulses");
  steady_a: assert property (serial_shift_clock_out
    || $fell(serial_shift_clock_out) |-> $stable(serial_result_out))
    else $error("Bit moved around a pulse");
  apb_rdy_a: assert property (apb_setup |=> pready_out ##1 !pready_out)
    else $error("Ready timing wrong");
  unmap_a: assert property (pready_out && paddr_in > sarrop_pkg::ADDR_RESULT
    |-> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("Unmapped access not refused");
endmodule // sarrop_assertions

bind sarrop_top sarrop_assertions i_chk (.*);

// ---- bench/sarrop_host_model.sv ----
// Host model: host shift clock frames and chain input.
`timescale 1ns/1ps
module sarrop_host_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic serial_result_in,
  output logic serial_shift_clock_out,
  output logic chain_out,
  output logic [23:0] word_out,
  output logic done_out
);
  localparam logic [7:0] PAT = 8'h2D;
  logic [2:0] ph_r;
  logic [4:0] n_r;
  logic run_r;
  ////////////////////////////////////////////////////////////////////////////
  // 24 pulses of 8 cycles: 160 ns, 80 ns high and low
  always_ff @(posedge clk_in)
  begin
    if (rst_in || (go_in && !run_r))
    begin
      run_r <= !rst_in;
      ph_r <= 3'h0;
      n_r <= 5'h00;
      done_out <= 1'b0;
      chain_out <= PAT[0];
    end
    else if (run_r)
    begin
      ph_r <= ph_r + 3'h1;
      // Chain moves at the fall, away from the next rise
      if (ph_r == 3'h3)
        chain_out <= PAT[n_r[2:0] + 3'h1];
      // Sample late in the low phase where the bit has settled
      if (ph_r == 3'h7)
      begin
        word_out <= {word_out[22:0], serial_result_in};
        n_r <= n_r + 5'h01;
        run_r <= n_r != 5'h17;
        done_out <= n_r == 5'h17;
      end
    end
  end
  // Clock stands low outside frames, so no edge hits a reload
  assign serial_shift_clock_out = run_r && !ph_r[2];
endmodule // sarrop_host_model

// ---- bench/test_sarrop_top.sv ----
// Self-checking bench for the result-output port.
`timescale 1ns/1ps
module test_sarrop_top;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic dev_sel_n_in = 1'b1;
  logic read_conv_in = 1'b1;
  logic half_sel_in = 1'b0;
  logic clk_src_ext_in = 1'b1;
  logic output_code_format_in = 1'b1;
  logic [15:0] sar_code_in = 16'h0000;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic go = 1'b0;
  logic chain_in, serial_shift_clock_in, serial_shift_clock_out, err;
  logic serial_shift_clock_oe_n_out, serial_result_out, busy_n_out;
  logic parallel_result_bus_oe_n_out, pready_out, pslverr_out, done;
  logic [7:0] parallel_result_bus_out;
  logic [31:0] prdata_out, rd;
  logic [23:0] word;
  int err_count = 0;
  int comparisons = 0;
  sarrop_top i_dut (.*);
  sarrop_host_model i_host (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .go_in(go),
    .serial_result_in(serial_result_out),
    .serial_shift_clock_out(serial_shift_clock_in),
    .chain_out(chain_in),
    .word_out(word),
    .done_out(done)
  );
  // 50 MHz clock
  initial
  begin
    forever #10 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string m);
  begin
    err_count++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  end
  endtask
  task automatic chk(input logic [31:0] g, e);
  begin
    comparisons++;
    if (g !== e)
      fail($sformatf("got %h want %h", g, e));
  end
  endtask
  task automatic complete_run;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task automatic cyc(input int n);
  begin
    repeat (n) @(posedge clk_in);
  end
  endtask
  // Bounded wait for busy high (w=0) or frame end (w=1)
  task automatic wait_hi(input bit w);
    int i;
  begin
    for (i = 0; i < 2000 && (w ? done : busy_n_out) !== 1'b1; i++)
      @(posedge clk_in);
    if ((w ? done : busy_n_out) !== 1'b1)
    begin
      fail("wait timed out");
      complete_run();
    end
  end
  endtask
  // One APB transfer; the idle edge after it avoids double drives
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
  begin
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_in);
      i++;
    end
    while (pready_out !== 1'b1 && i < 20);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1)
    begin
      fail("no ready");
      complete_run();
    end
    @(posedge clk_in);
  end
  endtask
  // Select first, then pull read/convert low
  task automatic convert(input logic [15:0] c);
  begin
    sar_code_in <= c;
    dev_sel_n_in <= 1'b0;
    cyc(1);
    read_conv_in <= 1'b0;
    cyc(6);
    read_conv_in <= 1'b1;
    dev_sel_n_in <= 1'b1;
    cyc(1);
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
  begin
    chk({busy_n_out, parallel_result_bus_oe_n_out, serial_result_out}, 3'h6);
    apb(1'b0, sarrop_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0004);
    apb(1'b0, 12'h00C, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("reset test done");
  end
  endtask
  task automatic t_parallel;
  begin
    convert(16'hC3A5);
    cyc(40);
    dev_sel_n_in <= 1'b0;
    cyc(4);
    chk(parallel_result_bus_out, 8'h00);
    apb(1'b1, sarrop_pkg::ADDR_CTRL, 32'h1);
    wait_hi(0);
    chk(parallel_result_bus_out, 8'hC3);
    half_sel_in <= 1'b1;
    cyc(4);
    chk(parallel_result_bus_out, 8'hA5);
    dev_sel_n_in <= 1'b1;
    half_sel_in <= 1'b0;
    cyc(4);
    chk(parallel_result_bus_oe_n_out, 1'b1);
    $display("parallel test done");
  end
  endtask
  task automatic t_format;
  begin
    sar_code_in <= 16'h1234;
    output_code_format_in <= 1'b0;
    apb(1'b1, sarrop_pkg::ADDR_CTRL, 32'h1);
    apb(1'b0, sarrop_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0005);
    wait_hi(0);
    apb(1'b0, sarrop_pkg::ADDR_RESULT, 32'h0);
    chk(rd, 32'h0000_9234);
    $display("format test done");
  end
  endtask
  // Internal clock: previous result leaves while the next converts
  task automatic t_int;
    int i, n;
    logic p;
    logic [15:0] w;
  begin
    clk_src_ext_in <= 1'b0;
    output_code_format_in <= 1'b1;
    cyc(8);
    convert(16'h0F0F);
    // Converting and internal transmitter both flagged, host mode clear
    apb(1'b0, sarrop_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0003);
    n = 0;
    p = 1'b0;
    w = 16'h0000;
    for (i = 0; i < 1500; i++)
    begin
      @(posedge clk_in);
      if (serial_shift_clock_out === 1'b1 && !p)
      begin
        w = {w[14:0], serial_result_out};
        n++;
      end
      p = serial_shift_clock_out;
    end
    chk(n, 16);
    chk(w, 16'h9234);
    chk({serial_shift_clock_out, serial_result_out}, 2'h1);
    $display("internal serial test done");
  end
  endtask
  // Host clock: an unselected frame is ignored, the next reads all
  task automatic t_ext;
    int k;
  begin
    clk_src_ext_in <= 1'b1;
    cyc(8);
    for (k = 0; k < 2; k++)
    begin
      dev_sel_n_in <= (k == 0);
      cyc(4);
      go <= 1'b1;
      cyc(1);
      go <= 1'b0;
      cyc(1);
      wait_hi(1);
    end
    chk(word[23:8], 16'h0F0F);
    chk(word[7:0], 8'hB4);
    dev_sel_n_in <= 1'b1;
    $display("host serial test done");
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(4);
    rst_in <= 1'b0;
    // Let the pin synchronisers fill before the first read
    cyc(4);
    t_reset();
    t_parallel();
    t_format();
    t_int();
    t_ext();
    complete_run();
  end
endmodule // test_sarrop_top
